// file: core/regbank_pkg.sv
// Purpose: Shared constants and types for the control and status register bank.
// Assumes: Registers are 8 bits wide and reached only through the two-wire target port.
// Notes:   Configuration tables list entries in index order, entry 0 in the top byte.
package regbank_pkg;

   // Fixed upper five bits of the 7-bit target address; straps supply the low two
   localparam logic [4:0] TGT_ADDR_HIGH = 5'h10;

   // Register offsets that are not held in the configuration table
   localparam logic [7:0] ADDR_ID_HIGH  = 8'h00;
   localparam logic [7:0] ADDR_ID_LOW   = 8'h01;
   localparam logic [7:0] ADDR_STATUS   = 8'h02;
   localparam logic [7:0] ADDR_IND      = 8'h03;
   localparam logic [7:0] ADDR_GAIN_RB1 = 8'h5A;
   localparam logic [7:0] ADDR_GAIN_RB2 = 8'h5B;
   localparam logic [7:0] ADDR_GAIN_RB3 = 8'h5C;

   // Value written to the low identification register that restores defaults
   localparam logic [7:0] SOFT_RESET_KEY = 8'hAA;

   // Number of writable configuration registers
   localparam int NUM_CFG = 41;

   // Table positions of registers the bank itself uses
   localparam int IDX_MASK   = 0;
   localparam int IDX_CTRL_A = 1;
   localparam int IDX_CTRL_B = 2;

   // Field positions
   localparam int ZC_BYPASS_BIT = 7;
   localparam int IRQ_SRC_BIT   = 5;
   localparam int WEN_MSB       = 7;
   localparam int WEN_LSB       = 6;
   localparam logic [1:0] WEN_PATTERN = 2'h2;

   // Offsets of the configuration registers, index 0 first
   localparam logic [NUM_CFG*8-1:0] CFG_ADDR_TABLE = {
      8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F,
      8'h10, 8'h11, 8'h12, 8'h13, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26,
      8'h27, 8'h28, 8'h29, 8'h2E, 8'h31, 8'h33, 8'h35, 8'h37, 8'h3C, 8'h3D, 8'h3E,
      8'h3F, 8'h40, 8'h42, 8'h49, 8'h4C, 8'h4F, 8'h54, 8'h55};

   // Default values of the configuration registers, same order
   localparam logic [NUM_CFG*8-1:0] CFG_RESET_TABLE = {
      8'hFF, 8'h03, 8'h3D, 8'h60, 8'h60, 8'h60, 8'h60, 8'h10, 8'h3F, 8'h10, 8'h3F,
      8'h10, 8'h3F, 8'h10, 8'h3F, 8'h08, 8'h14, 8'h00, 8'h1F, 8'h1F, 8'h1C, 8'h00,
      8'h01, 8'h10, 8'h11, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00,
      8'h00, 8'h01, 8'h01, 8'h10, 8'h88, 8'hFF, 8'h44, 8'hC4};

   // Target port sequencer states, one-hot
   typedef enum logic [8:0] {
      ST_IDLE     = 9'h001,  // Not addressed, line released
      ST_ADDR     = 9'h002,  // Shifting in address and direction
      ST_ADDR_ACK = 9'h004,  // Acknowledging own address
      ST_PTR      = 9'h008,  // Shifting in register pointer
      ST_PTR_ACK  = 9'h010,  // Acknowledging pointer
      ST_WDATA    = 9'h020,  // Shifting in write data
      ST_WACK     = 9'h040,  // Acknowledging write data
      ST_RDATA    = 9'h080,  // Shifting out read data
      ST_RACK     = 9'h100   // Waiting for host acknowledge
   } port_state_e;

endpackage

// file: core/regbank_i2c.sv
// Purpose: Two-wire target port and register bank with fault status and interrupt indicators.
// Assumes: clk is much faster than the serial clock; serial pins and straps are asynchronous.
// Notes:   The serial clock is oversampled, never used as a clock; no clock stretching.

// What this block does
// [R1] Acknowledge only own address on write-direction start
// [R2] Acknowledge and store one register pointer byte
// [R3] Pointer survives stop/start and repeated start
// [R4] Matching read address: acknowledge, send register MSB-first
// [R5] Host acknowledge increments pointer, sends next register
// [R6] Stop releases data line, ends transmission
// [R7] Two identification registers return fixed values
// [R8] Writing 0xAA to low ID restores defaults
// [R9] Status bits 7..3 report live clock faults
// [R10] Status bit 2 reports system clock stable
// [R11] Status bits 1..0 report bias overcurrent
// [R12] Indicator register clears when read
// [R13] Mask register suppresses interrupt pin sources, not indicators, resets all masked
// [R14] Control A bit 7 selects zero-cross volume bypass
// [R15] Target address is 10000 plus two straps
// [R16] Write data bytes increment pointer at end of byte, as acknowledge begins
// [R17] Writes need enable field equal to 10, except to control B itself and the soft reset key
// [R18] Control bit selects interrupt pin source
// [R19] Indicator latches on status rise until read
// [R20] Unmasked set indicator asserts interrupt output
module regbank_i2c #(
   parameter logic [7:0] CHIP_ID_HIGH = 8'h5A,  // Arbitrary identification value
   parameter logic [7:0] CHIP_ID_LOW  = 8'hC3   // Arbitrary identification value
) (
   // Clock, reset and freeze
   input  wire logic                            clk,
   input  wire logic                            rst_n,
   input  wire logic                            ce,
   // Serial control pins
   input  wire logic                            scl_in,
   input  wire logic                            sda_in,
   output logic                                 sda_out,
   output logic                                 sda_oe,
   // Address straps
   input  wire logic                            address_strap_low,
   input  wire logic                            address_strap_high,
   // Live fault and clock conditions from the monitors
   input  wire logic                            bitclk_error_status,
   input  wire logic                            master_clock_missing_status,
   input  wire logic                            frame_clock_missing_status,
   input  wire logic                            bitclk_missing_status,
   input  wire logic                            serial_clocks_missing_status,
   input  wire logic                            system_clock_stable_status,
   input  wire logic                            bias_pair34_overcurrent_status,
   input  wire logic                            bias_pair12_overcurrent_status,
   // Gain readback from the amplifiers
   input  wire logic [7:0]                      amp1_gain_readback,
   input  wire logic [7:0]                      amp2_gain_readback,
   input  wire logic [7:0]                      amp3_gain_readback,
   // Configuration out to the datapath
   output logic [regbank_pkg::NUM_CFG*8-1:0]    cfg_regs,
   output logic                                 volume_zero_cross_bypass,
   // Interrupt pin, active high
   output logic                                 irq
);

   // Whole state of the block
   typedef struct packed {
      regbank_pkg::port_state_e          st;        // Port sequencer state
      logic                              scl_s1;    // Synchroniser first stages
      logic                              scl_s2;
      logic                              sda_s1;
      logic                              sda_s2;
      logic                              scl_q;     // Previous synchronised levels
      logic                              sda_q;
      logic [1:0]                        strap_s1;
      logic [1:0]                        strap_s2;
      logic [3:0]                        bitcnt;    // Bits moved in current byte
      logic [7:0]                        shreg;     // Shift register, both directions
      logic [7:0]                        ptr;       // Current register pointer
      logic                              rw;        // Direction bit of last address
      logic                              hack;      // Host acknowledged last read byte
      logic [7:0]                        stat_q;    // Status one cycle ago, for rise detect
      logic [7:0]                        ind;       // Interrupt indicators
      logic [regbank_pkg::NUM_CFG*8-1:0] cfg;       // Writable configuration
   } bank_s;

   bank_s r;    // Registered state
   bank_s nxt;  // Next state

   logic [7:0] status_now;  // Live status byte
   logic       scl_rise;
   logic       scl_fall;
   logic       start_ev;
   logic       stop_ev;
   logic       addr_match;
   logic       load_rd;     // A read byte is fetched this cycle
   logic       wr_stb;      // A write data byte completes this cycle
   logic       wr_ok;       // Write is permitted
   logic [7:0] rise_ev;     // Status bits that became active
   logic [7:0] ctrl_a;      // Control A image
   logic [7:0] ctrl_b;      // Control B image
   logic [7:0] irq_masks;   // Interrupt mask image

   // Configuration table lookup: offset to index, with hit flag
   function automatic logic [6:0] cfg_find(input logic [7:0] a);
      logic [6:0] res;
      res = 7'h00;
      for (int i = 0; i < regbank_pkg::NUM_CFG; i++) begin
         if (regbank_pkg::CFG_ADDR_TABLE[(regbank_pkg::NUM_CFG-1-i)*8 +: 8] == a) begin
            res = {1'b1, 6'(i)};
         end
      end
      return res;
   endfunction

   // Byte of the configuration image at a given index
   function automatic logic [7:0] cfg_byte(input logic [regbank_pkg::NUM_CFG*8-1:0] c, input int i);
      return c[(regbank_pkg::NUM_CFG-1-i)*8 +: 8];
   endfunction

   // Read value of any register; unmapped offsets read zero
   function automatic logic [7:0] rd_byte(input logic [7:0] a, input bank_s s, input logic [7:0] st_now);
      logic [6:0] f;
      logic [7:0] v;
      f = cfg_find(a);
      v = 8'h00;
      if (f[6]) begin
         v = cfg_byte(s.cfg, int'(f[5:0]));
      end else begin
         unique case (a)
            regbank_pkg::ADDR_ID_HIGH:  v = CHIP_ID_HIGH;      // [R7]
            regbank_pkg::ADDR_ID_LOW:   v = CHIP_ID_LOW;       // [R7]
            regbank_pkg::ADDR_STATUS:   v = st_now;            // [R9] [R10] [R11]
            regbank_pkg::ADDR_IND:      v = s.ind;             // [R12]
            regbank_pkg::ADDR_GAIN_RB1: v = amp1_gain_readback;
            regbank_pkg::ADDR_GAIN_RB2: v = amp2_gain_readback;
            regbank_pkg::ADDR_GAIN_RB3: v = amp3_gain_readback;
            default:                    v = 8'h00;
         endcase
      end
      return v;
   endfunction

   // Live status byte in documented bit order
   assign status_now = {bitclk_error_status, master_clock_missing_status,        // [R9]
                        frame_clock_missing_status, bitclk_missing_status,
                        serial_clocks_missing_status,
                        system_clock_stable_status,                              // [R10]
                        bias_pair34_overcurrent_status,                          // [R11]
                        bias_pair12_overcurrent_status};

   // Line events from the synchronised levels
   assign scl_rise = r.scl_s2 & ~r.scl_q;
   assign scl_fall = ~r.scl_s2 & r.scl_q;
   assign start_ev = r.scl_s2 & r.scl_q & r.sda_q & ~r.sda_s2;
   assign stop_ev  = r.scl_s2 & r.scl_q & ~r.sda_q & r.sda_s2;

   // Own address is the fixed high part with the strapped low bits
   assign addr_match = (r.shreg[7:1] == {regbank_pkg::TGT_ADDR_HIGH, r.strap_s2});  // [R15] [R1]

   // Control and mask register images
   assign ctrl_a    = cfg_byte(r.cfg, regbank_pkg::IDX_CTRL_A);
   assign ctrl_b    = cfg_byte(r.cfg, regbank_pkg::IDX_CTRL_B);
   assign irq_masks = cfg_byte(r.cfg, regbank_pkg::IDX_MASK);
   // Writes land only when the enable field holds its pattern; that register itself
   // stays writable, otherwise the enable could never be set after reset
   assign wr_ok = (ctrl_b[regbank_pkg::WEN_MSB:regbank_pkg::WEN_LSB] == regbank_pkg::WEN_PATTERN)
                  || (r.ptr == regbank_pkg::CFG_ADDR_TABLE[(regbank_pkg::NUM_CFG-1-regbank_pkg::IDX_CTRL_B)*8 +: 8]);

   // Byte fetch and write strobes used by the indicator clear and the assertions
   assign load_rd = ce & scl_fall & ~start_ev & ~stop_ev &
                    (((r.st == regbank_pkg::ST_ADDR_ACK) & r.rw) | ((r.st == regbank_pkg::ST_RACK) & r.hack));
   assign wr_stb  = ce & scl_fall & ~start_ev & ~stop_ev & (r.st == regbank_pkg::ST_WDATA) & (r.bitcnt == 4'h8);
   assign rise_ev = status_now & ~r.stat_q;

   // Next-state logic
   always_comb begin
      logic [6:0] f;
      f = cfg_find(r.ptr);
      nxt = r;
      // Synchronisers: the first stage feeds only the second
      nxt.scl_s1   = scl_in;
      nxt.scl_s2   = r.scl_s1;
      nxt.sda_s1   = sda_in;
      nxt.sda_s2   = r.sda_s1;
      nxt.strap_s1 = {address_strap_high, address_strap_low};
      nxt.strap_s2 = r.strap_s1;
      nxt.scl_q    = r.scl_s2;
      nxt.sda_q    = r.sda_s2;
      nxt.stat_q   = status_now;

      // Sequencer; start and stop win over bit traffic
      if (stop_ev) begin
         nxt.st = regbank_pkg::ST_IDLE;                          // [R6]
      end else if (start_ev) begin
         nxt.st     = regbank_pkg::ST_ADDR;                      // [R3]
         nxt.bitcnt = 4'h0;
      end else if (scl_rise) begin
         unique case (r.st)
            regbank_pkg::ST_ADDR, regbank_pkg::ST_PTR, regbank_pkg::ST_WDATA: begin
               nxt.shreg  = {r.shreg[6:0], r.sda_s2};
               nxt.bitcnt = r.bitcnt + 4'h1;
            end
            regbank_pkg::ST_RDATA: begin
               nxt.bitcnt = r.bitcnt + 4'h1;
            end
            regbank_pkg::ST_RACK: begin
               // Host acknowledge moves the pointer on
               nxt.hack = ~r.sda_s2;
               if (!r.sda_s2) begin
                  nxt.ptr = r.ptr + 8'h01;                       // [R5]
               end
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         unique case (r.st)
            regbank_pkg::ST_ADDR: begin
               if (r.bitcnt == 4'h8) begin
                  nxt.rw = r.shreg[0];
                  nxt.st = addr_match ? regbank_pkg::ST_ADDR_ACK : regbank_pkg::ST_IDLE;  // [R1]
               end
            end
            regbank_pkg::ST_ADDR_ACK: begin
               nxt.bitcnt = 4'h0;
               if (r.rw) begin
                  nxt.shreg = rd_byte(r.ptr, r, status_now);     // [R4]
                  nxt.st    = regbank_pkg::ST_RDATA;
               end else begin
                  nxt.st = regbank_pkg::ST_PTR;
               end
            end
            regbank_pkg::ST_PTR: begin
               if (r.bitcnt == 4'h8) begin
                  nxt.ptr = r.shreg;                             // [R2]
                  nxt.st  = regbank_pkg::ST_PTR_ACK;
               end
            end
            regbank_pkg::ST_PTR_ACK, regbank_pkg::ST_WACK: begin
               nxt.bitcnt = 4'h0;
               nxt.st     = regbank_pkg::ST_WDATA;
            end
            regbank_pkg::ST_WDATA: begin
               if (r.bitcnt == 4'h8) begin
                  nxt.st  = regbank_pkg::ST_WACK;
                  nxt.ptr = r.ptr + 8'h01;                       // [R16]
                  if (r.ptr == regbank_pkg::ADDR_ID_LOW && r.shreg == regbank_pkg::SOFT_RESET_KEY) begin
                     nxt.cfg = regbank_pkg::CFG_RESET_TABLE;     // [R8]
                  end else if (f[6] && wr_ok) begin
                     nxt.cfg[(regbank_pkg::NUM_CFG-1-int'(f[5:0]))*8 +: 8] = r.shreg;  // [R17]
                  end
               end
            end
            regbank_pkg::ST_RDATA: begin
               if (r.bitcnt == 4'h8) begin
                  nxt.st   = regbank_pkg::ST_RACK;
                  nxt.hack = 1'b0;
               end else begin
                  nxt.shreg = {r.shreg[6:0], 1'b0};              // [R4]
               end
            end
            regbank_pkg::ST_RACK: begin
               nxt.bitcnt = 4'h0;
               if (r.hack) begin
                  nxt.shreg = rd_byte(r.ptr, r, status_now);     // [R5]
                  nxt.st    = regbank_pkg::ST_RDATA;
               end else begin
                  // Not acknowledged: stop sending and wait for stop or start
                  nxt.st = regbank_pkg::ST_IDLE;
               end
            end
            default: begin
            end
         endcase
      end

      // Indicators: fetching the register clears, a new rise in the same cycle survives
      if (load_rd && r.ptr == regbank_pkg::ADDR_IND) begin
         nxt.ind = 8'h00;                                        // [R12]
      end
      nxt.ind = nxt.ind | rise_ev;                               // [R19]

      // Clock enable low freezes everything
      if (!ce) begin
         nxt = r;
      end
   end

   // State register; asynchronous reset to constants only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r          <= '0;
         r.st       <= regbank_pkg::ST_IDLE;
         r.scl_s1   <= 1'b1;
         r.scl_s2   <= 1'b1;
         r.sda_s1   <= 1'b1;
         r.sda_s2   <= 1'b1;
         r.scl_q    <= 1'b1;
         r.sda_q    <= 1'b1;
         r.cfg      <= regbank_pkg::CFG_RESET_TABLE;              // [R13]
      end else begin
         r <= nxt;
      end
   end

   // Open-drain data pin: only ever pulled low
   assign sda_out = 1'b0;
   assign sda_oe  = (r.st == regbank_pkg::ST_ADDR_ACK) || (r.st == regbank_pkg::ST_PTR_ACK) ||  // [R1] [R2]
                    (r.st == regbank_pkg::ST_WACK) ||
                    ((r.st == regbank_pkg::ST_RDATA) && !r.shreg[7]);                         // [R4] [R6]

   // Configuration outputs straight from flip-flops
   assign cfg_regs                 = r.cfg;
   assign volume_zero_cross_bypass = ctrl_a[regbank_pkg::ZC_BYPASS_BIT];  // [R14]

   // Interrupt pin source: masked indicators or masked live status
   assign irq = ctrl_a[regbank_pkg::IRQ_SRC_BIT]
                ? |(status_now & ~irq_masks)  // [R18]
                : |(r.ind & ~irq_masks);      // [R20] [R13]

   // Acknowledge of the address only for a match
   property p_addr_ack;
      @(posedge clk) disable iff (!rst_n)
      (r.st == regbank_pkg::ST_ADDR_ACK) |-> sda_oe && addr_match;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("address acknowledged without match"); // [R1] [R15]

   // Pointer byte stored as its acknowledge begins
   property p_ptr_store;
      @(posedge clk) disable iff (!rst_n)
      (r.st == regbank_pkg::ST_PTR && nxt.st == regbank_pkg::ST_PTR_ACK && ce)
         |=> sda_oe && r.ptr == $past(r.shreg);
   endproperty
   a_ptr_store: assert property (p_ptr_store) else $error("pointer byte not stored"); // [R2]

   // Start keeps the pointer
   property p_ptr_keep;
      @(posedge clk) disable iff (!rst_n)
      (start_ev && ce) |=> (r.ptr == $past(r.ptr)) && (r.st == regbank_pkg::ST_ADDR);
   endproperty
   a_ptr_keep: assert property (p_ptr_keep) else $error("start changed the pointer"); // [R3]

   // Read byte on the line, MSB first
   property p_rd_drive;
      @(posedge clk) disable iff (!rst_n)
      (r.st == regbank_pkg::ST_RDATA && scl_fall && r.bitcnt != 4'h8 && !start_ev && !stop_ev && ce)
         |=> sda_oe == !$past(r.shreg[6]);
   endproperty
   a_rd_drive: assert property (p_rd_drive) else $error("read bit not driven"); // [R4]

   // Host acknowledge advances the pointer by one
   property p_rd_inc;
      @(posedge clk) disable iff (!rst_n)
      (r.st == regbank_pkg::ST_RACK && scl_rise && !r.sda_s2 && !start_ev && !stop_ev && ce)
         |=> r.ptr == $past(r.ptr) + 8'h01;
   endproperty
   a_rd_inc: assert property (p_rd_inc) else $error("pointer not advanced on acknowledge"); // [R5]

   // Stop releases the line next cycle and returns the sequencer to idle
   property p_stop_release;
      @(posedge clk) disable iff (!rst_n)
      (stop_ev && ce) |=> (!sda_oe && r.st == regbank_pkg::ST_IDLE);
   endproperty
   a_stop_release: assert property (p_stop_release) else $error("line held after stop"); // [R6]

   // Soft reset restores every configuration default
   property p_soft_reset;
      @(posedge clk) disable iff (!rst_n)
      (wr_stb && r.ptr == regbank_pkg::ADDR_ID_LOW && r.shreg == regbank_pkg::SOFT_RESET_KEY)
         |=> r.cfg == regbank_pkg::CFG_RESET_TABLE;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed"); // [R8]

   // Blocked writes leave the configuration alone
   property p_wr_block;
      @(posedge clk) disable iff (!rst_n)
      (wr_stb && !wr_ok && r.ptr != regbank_pkg::ADDR_ID_LOW) |=> $stable(r.cfg);
   endproperty
   a_wr_block: assert property (p_wr_block) else $error("write landed while disabled"); // [R17]

   // A rising status bit sets its indicator, even during a clearing read
   property p_ind_set;
      @(posedge clk) disable iff (!rst_n)
      (ce && rise_ev != 8'h00) |=> ((r.ind & $past(rise_ev)) == $past(rise_ev));
   endproperty
   a_ind_set: assert property (p_ind_set) else $error("indicator not latched"); // [R19]

   // Reading the indicators clears all bits without a new rise
   property p_ind_clear;
      @(posedge clk) disable iff (!rst_n)
      (load_rd && r.ptr == regbank_pkg::ADDR_IND) |=> r.ind == $past(rise_ev);
   endproperty
   a_ind_clear: assert property (p_ind_clear) else $error("indicators not cleared by read"); // [R12]

   // Interrupt pin follows unmasked indicators when so selected
   property p_irq_ind;
      @(posedge clk) disable iff (!rst_n)
      !ctrl_a[regbank_pkg::IRQ_SRC_BIT] |-> irq == |(r.ind & ~irq_masks);
   endproperty
   a_irq_ind: assert property (p_irq_ind) else $error("interrupt pin wrong"); // [R20] [R18] [R13]

endmodule

// file: tb/i2c_host_model.sv
// Purpose: Behavioural two-wire bus host driving SCL and pulling or releasing SDA.
// Assumes: SDA has a pull-up; sda is the resolved line level.
// Notes:   124.5 ns bit period; SCL stands high between transfers.
module i2c_host_model (
   // Bus lines
   output logic      scl,
   output logic      sda_rel,
   input  wire logic sda
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle bus at time zero
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end
   // One bit: data moves well after the fall, sampled mid-high so the device's bit has settled
   task automatic bit_io(input logic b, output logic s);
      scl = 1'b0;
      #32 sda_rel = b;
      #30 scl = 1'b1;
      #31 s = sda;
      #31.5;
   endtask
   // Start or repeated start: SDA falls while SCL is high
   task automatic start();
      logic s;
      bit_io(1'b1, s);
      sda_rel = 1'b0;
      #31;
   endtask
   // Stop: SDA rises while SCL is high, ends the transfer
   task automatic stop();
      logic s;
      bit_io(1'b0, s);
      sda_rel = 1'b1;
      #31;
   endtask
   // Eight bits MSB first, then the ninth acknowledge slot
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) bit_io(tx[i], rx[i]);
   endtask
endmodule

// file: tb/regbank_i2c_bench.sv
// Purpose: Self-checking bench for the register bank behind the two-wire target port.
// Assumes: The host model owns SCL; SDA is resolved here with its pull-up.
// Notes:   Status, masks, straps and gains come from a fixed-seed LFSR, with an all-ones status and all-zeros mask corner.
`define CHK(n, e, g) cmp(n, e, g)
`define H i2c_host_model_inst
module regbank_i2c_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] ID_H = 8'h96;  // Arbitrary identification value
   localparam logic [7:0] ID_L = 8'h69;  // Arbitrary identification value
   logic                              clk, rst_n, scl, sda_rel, sda_oe, sda_out, irq, vzc;
   logic [1:0]                        strap;          // Address straps
   logic [7:0]                        st, g1, g2, g3; // Live status and gain readbacks
   logic [8:0]                        rx;             // Byte and ninth bit seen by the host
   logic [31:0]                       lfsr_q;         // Random source state
   logic [regbank_pkg::NUM_CFG*8-1:0] cfg;
   int                                miscompares, check_count;
   wire logic                         sda = sda_rel & ~(sda_oe & ~sda_out); // Open drain, pull-up
   always #5 clk = ~clk;
   regbank_i2c #(.CHIP_ID_HIGH(ID_H), .CHIP_ID_LOW(ID_L)) regbank_i2c_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .address_strap_low(strap[0]),
      .address_strap_high(strap[1]), .bitclk_error_status(st[7]), .master_clock_missing_status(st[6]),
      .frame_clock_missing_status(st[5]), .bitclk_missing_status(st[4]), .serial_clocks_missing_status(st[3]),
      .system_clock_stable_status(st[2]), .bias_pair34_overcurrent_status(st[1]),
      .bias_pair12_overcurrent_status(st[0]), .amp1_gain_readback(g1), .amp2_gain_readback(g2),
      .amp3_gain_readback(g3), .cfg_regs(cfg), .volume_zero_cross_bypass(vzc), .irq(irq));
   i2c_host_model i2c_host_model_inst (.scl(scl), .sda_rel(sda_rel), .sda(sda));
   // Fixed-seed LFSR, one byte per call
   function automatic logic [7:0] rnd();
      lfsr_q = {lfsr_q[30:0], ^(lfsr_q & 32'h80200003)};
      return lfsr_q[7:0];
   endfunction
   // Expected interrupt pin from pending or live bits and masks
   function automatic logic [7:0] exp_irq(input logic [7:0] s, input logic [7:0] m);
      return {7'h0, |(s & ~m)};
   endfunction
   // Own target address byte with direction bit
   function automatic logic [7:0] adr(input logic rw);
      return {regbank_pkg::TGT_ADDR_HIGH, strap, rw};
   endfunction
   // Four-state compare, counted
   task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Single exit of the run
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Whole configuration image against its defaults
   task automatic cfg_defaults();
      for (int i = 0; i < regbank_pkg::NUM_CFG; i++) `CHK("cfg", regbank_pkg::CFG_RESET_TABLE[i*8+:8], cfg[i*8+:8]);
   endtask
   // Address for write, then the pointer byte
   task automatic set_ptr(input logic [7:0] p);
      `H.start();
      `H.xfer({adr(1'b0), 1'b1}, rx);
      `CHK("addr ack", 8'h00, rx[0]);
      `H.xfer({p, 1'b1}, rx);
      `CHK("ptr ack", 8'h00, rx[0]);
   endtask
   // Burst write, then stop; the line must be let go afterwards
   task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
      set_ptr(p);
      foreach (d[i]) `H.xfer({d[i], 1'b1}, rx);
      `CHK("data ack", 8'h00, rx[0]);
      `H.stop();
      repeat (6) @(negedge clk);
      `CHK("released", 8'h00, sda_oe);
   endtask
   // Pointer, then stop plus start or a repeated start, then n bytes; last one not acknowledged
   task automatic rd(input logic [7:0] p, input logic sep, input int n, output logic [7:0] q[$]);
      q = {};
      set_ptr(p);
      if (sep) `H.stop();
      `H.start();
      `H.xfer({adr(1'b1), 1'b1}, rx);
      `CHK("read ack", 8'h00, rx[0]);
      for (int i = 0; i < n; i++) begin
         `H.xfer({8'hFF, i == n - 1}, rx);
         q.push_back(rx[8:1]);
      end
      `H.stop();
      repeat (6) @(negedge clk);
   endtask
   // Main sequence
   initial begin
      logic [7:0] q[$];
      logic [7:0] s, m;
      clk = 1'b0;
      rst_n = 1'b0;
      lfsr_q = 32'h6A48;
      st = 8'h00;
      g1 = rnd();
      g2 = rnd();
      g3 = rnd();
      s = rnd();
      strap = s[1:0];
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      cfg_defaults();
      rd(8'h00, 1'b0, 5, q);
      `CHK("id high", ID_H, q[0]);
      `CHK("id low", ID_L, q[1]);
      `CHK("status idle", 8'h00, q[2]);
      `CHK("mask reset", 8'hFF, q[4]);
      rd(8'h5A, 1'b1, 3, q);
      `CHK("gain one", g1, q[0]);
      `CHK("gain three", g3, q[2]);
      `H.start();
      `H.xfer({adr(1'b0) ^ 8'h08, 1'b1}, rx);
      `CHK("foreign nack", 8'h01, rx[0]);
      `H.stop();
      wr(8'h06, '{8'hA0});
      rd(8'h06, 1'b0, 1, q);
      `CHK("locked", 8'h03, q[0]);
      wr(8'h07, '{8'hBD});
      for (int k = 0; k < 6; k++) begin
         s = (k == 0) ? 8'hFF : rnd();
         m = (k == 0) ? 8'h00 : rnd();
         wr(8'h04, '{m, 8'h00, 8'h80});
         rd(8'h04, 1'b0, 3, q);
         `CHK("mask", m, q[0]);
         `CHK("ctrl a", 8'h80, q[2]);
         `CHK("bypass", 8'h01, vzc);
         st = s;
         repeat (3) @(negedge clk);
         `CHK("irq pending", exp_irq(s, m), irq);
         rd(8'h02, 1'b0, 2, q);
         `CHK("status", s, q[0]);
         `CHK("latched", s, q[1]);
         rd(8'h03, 1'b1, 1, q);
         `CHK("cleared", 8'h00, q[0]);
         `CHK("irq idle", 8'h00, irq);
         wr(8'h06, '{8'hA0});
         `CHK("irq live", exp_irq(s, m), irq);
         st = 8'h00;
      end
      wr(8'h01, '{8'hAA});
      cfg_defaults();
      `CHK("bypass off", 8'h00, vzc);
      give_verdict();
   end
   // Watchdog: the sequence needs well under this span
   initial begin
      #900us;
      miscompares++;
      give_verdict();
   end
endmodule
